// file: design/hlsr_pkg.sv
package hlsr_pkg;

	// Outgoing-data destination
	typedef enum logic [0:0] {
		HLSR_DEST_SERIAL = 1'h0,
		HLSR_DEST_USB    = 1'h1
	} hlsr_dest_t;

	// Serial port mode from {jumper_b, jumper_a}, open = 1, short = 0
	typedef enum logic [1:0] {
		HLSR_MODE_UART = 2'h0,
		HLSR_MODE_I2C  = 2'h2,
		HLSR_MODE_SPI  = 2'h3,
		HLSR_MODE_RSVD = 2'h1
	} hlsr_mode_t;

	// Link activity reported by the protocol engines, one-cycle pulses
	typedef struct packed {
		logic usb_bulk_in_ep1;
		logic usb_bulk_out_ep2;
		logic uart_rx_byte;
		logic spi_write_cmd;
		logic spi_read_cmd;
		logic spi_status_cmd;
		logic i2c_addr_match;
	} hlsr_event_t;

	// Jumper and strap levels as decoded
	typedef struct packed {
		hlsr_mode_t mode;
		logic [1:0] addr_sel;
		logic [1:0] baud_sel;
		logic       autostart;
		logic       test_mode;
	} hlsr_cfg_t;

	localparam logic [11:0] HLSR_RX_BUSY_SPACE  = 12'h03e;
	localparam logic [11:0] HLSR_RX_READY_SPACE = 12'h080;
	localparam logic [7:0]  HLSR_FILLER_BYTE    = 8'hff;
	localparam logic [6:0]  HLSR_I2C_ADDR_BASE  = 7'h50;

endpackage

// file: design/hlsr_route.sv
`timescale 1ns/1ps
`default_nettype none
// Destination selector; byte-atomic change so a byte never straddles two links
module hlsr_route (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire hlsr_pkg::hlsr_mode_t mode,
	input  wire hlsr_pkg::hlsr_event_t ev,
	input  wire logic                 byte_busy,
	output var  hlsr_pkg::hlsr_dest_t dest
);

	typedef struct packed {
		hlsr_pkg::hlsr_dest_t dest;
		hlsr_pkg::hlsr_dest_t want;
		logic                 pend;
	} hlsr_route_st_t;

	hlsr_route_st_t st_r;
	hlsr_route_st_t st_nxt;
	logic           usb_hit;
	logic           ser_hit;

	always_comb begin
		usb_hit = ev.usb_bulk_in_ep1 | ev.usb_bulk_out_ep2;
		ser_hit = 1'b0;
		unique case (mode)
			hlsr_pkg::HLSR_MODE_UART: ser_hit = ev.uart_rx_byte;
			hlsr_pkg::HLSR_MODE_SPI:  ser_hit = ev.spi_write_cmd | ev.spi_read_cmd
				| ev.spi_status_cmd;
			hlsr_pkg::HLSR_MODE_I2C:  ser_hit = ev.i2c_addr_match;
			hlsr_pkg::HLSR_MODE_RSVD: ser_hit = 1'b0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// Simultaneous hits: USB wins, being the later-sampled link by convention
		if (usb_hit) begin
			st_nxt.want = hlsr_pkg::HLSR_DEST_USB;
			st_nxt.pend = 1'b1;
		end else if (ser_hit) begin
			st_nxt.want = hlsr_pkg::HLSR_DEST_SERIAL;
			st_nxt.pend = 1'b1;
		end
		// Change only between bytes; remaining buffer drains on the new link
		if (st_nxt.pend && !byte_busy) begin
			st_nxt.dest = st_nxt.want;
			st_nxt.pend = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{hlsr_pkg::HLSR_DEST_SERIAL, hlsr_pkg::HLSR_DEST_SERIAL, 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dest = st_r.dest;

endmodule
`default_nettype wire

// file: design/hlsr_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - After power-up or reset, outgoing data goes to the serial port.
// - USB bulk IN on endpoint 1 or bulk OUT on endpoint 2 selects USB.
// - In SPI mode an SPI write/read/status command, in UART mode any UART byte, selects serial.
// - In I2C mode, own address with R/W bit selects serial.
// - Bytes left in transmit buffer go out on the newly selected link.
// - Low level on the reset input resets the device.
// - Busy, transmit data and transmit-ready float during reset and initialization.
// - Autostart: accept bytes after busy drops, defer execution until loading done.
// - Test strap low enters test mode; open means normal operation.
// - Each jumper reads high when open and low when shorted.
// - Busy at 62 free bytes or less; ready at 128 or more.
// - Transmit-ready shows whether the transmit buffer holds any byte.
// - Empty transmit buffer answers SPI or I2C reads with FFh.
module hlsr_top (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  test_strap_n,
	input  wire logic                  serial_mode_jumper_a,
	input  wire logic                  serial_mode_jumper_b,
	input  wire logic                  slave_addr_jumper_a,
	input  wire logic                  slave_addr_jumper_b,
	input  wire logic                  baud_jumper_a,
	input  wire logic                  baud_jumper_b,
	input  wire logic                  app_autostart_jumper,
	input  wire logic                  init_done,
	input  wire logic                  load_done,
	input  wire hlsr_pkg::hlsr_event_t link_ev,
	input  wire logic [11:0]           rx_free_space,
	input  wire logic                  tx_empty,
	input  wire logic [7:0]            tx_head_byte,
	input  wire logic                  tx_byte_busy,
	input  wire logic                  serial_txd_in,
	output var  hlsr_pkg::hlsr_dest_t  tx_dest,
	output var  hlsr_pkg::hlsr_cfg_t   cfg,
	output logic [6:0]                 i2c_own_addr,
	output logic [7:0]                 read_byte,
	output logic                       exec_enable,
	output logic                       rx_full_indicator_o,
	output logic                       rx_full_indicator_oe,
	output logic                       serial_txd_o,
	output logic                       serial_txd_oe,
	output logic                       tx_pending_flag_o,
	output logic                       tx_pending_flag_oe
);

	typedef struct packed {
		logic                sync1;
		logic                sync2;
		logic                cfg_vld;
		hlsr_pkg::hlsr_cfg_t cfg;
		logic                busy;
		logic                txd;
		logic                pend;
		logic [7:0]          rbyte;
		logic                exec;
		logic                drive;
	} hlsr_st_t;

	hlsr_st_t st_r;
	hlsr_st_t st_nxt;
	logic     srst_n;

	assign srst_n = st_r.sync2;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.sync1 = 1'b1;
		st_nxt.sync2 = st_r.sync1;
		// Jumpers are caught once after reset release; moving them later has no effect
		if (st_r.sync2 && !st_r.cfg_vld) begin
			st_nxt.cfg_vld       = 1'b1;
			st_nxt.cfg.mode      = hlsr_pkg::hlsr_mode_t'({serial_mode_jumper_b,
				serial_mode_jumper_a});
			st_nxt.cfg.addr_sel  = {slave_addr_jumper_b, slave_addr_jumper_a};
			st_nxt.cfg.baud_sel  = {baud_jumper_b, baud_jumper_a};
			st_nxt.cfg.autostart = ~app_autostart_jumper;
			st_nxt.cfg.test_mode = ~test_strap_n;
		end
		// Hysteresis between the two thresholds
		if (rx_free_space <= hlsr_pkg::HLSR_RX_BUSY_SPACE) begin
			st_nxt.busy = 1'b1;
		end else if (rx_free_space >= hlsr_pkg::HLSR_RX_READY_SPACE) begin
			st_nxt.busy = 1'b0;
		end
		st_nxt.pend  = ~tx_empty;
		st_nxt.rbyte = tx_empty ? hlsr_pkg::HLSR_FILLER_BYTE : tx_head_byte;
		st_nxt.txd   = (tx_dest == hlsr_pkg::HLSR_DEST_SERIAL) ? serial_txd_in : 1'b1;
		st_nxt.drive = st_r.cfg_vld & init_done;
		st_nxt.exec  = st_r.cfg_vld & init_done & (~st_r.cfg.autostart | load_done);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r       <= '0;
			st_r.busy  <= 1'b1;
			st_r.rbyte <= hlsr_pkg::HLSR_FILLER_BYTE;
			st_r.txd   <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	hlsr_route hlsr_route_inst (
		.clk       (clk),
		.rst_n     (srst_n),
		.mode      (st_r.cfg.mode),
		.ev        (link_ev),
		.byte_busy (tx_byte_busy),
		.dest      (tx_dest)
	);

	assign cfg          = st_r.cfg;
	assign i2c_own_addr = hlsr_pkg::HLSR_I2C_ADDR_BASE | {5'h00, ~st_r.cfg.addr_sel};
	assign read_byte    = st_r.rbyte;
	assign exec_enable  = st_r.exec;

	// Released pins read high through the external pull-up, which the host sees as busy
	assign rx_full_indicator_o  = st_r.busy;
	assign rx_full_indicator_oe = st_r.drive;
	assign serial_txd_o         = st_r.txd;
	assign serial_txd_oe        = st_r.drive;
	assign tx_pending_flag_o    = st_r.pend;
	assign tx_pending_flag_oe   = st_r.drive;

endmodule
`default_nettype wire

// file: tb/hlsr_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hlsr_top_chk (
	input wire logic			clk,
	input wire logic			rst_n,
	input wire hlsr_pkg::hlsr_event_t	link_ev,
	input wire logic [11:0]			rx_free_space,
	input wire logic			tx_empty,
	input wire logic			tx_byte_busy,
	input wire hlsr_pkg::hlsr_dest_t	tx_dest,
	input wire hlsr_pkg::hlsr_cfg_t		cfg,
	input wire logic			rx_full_indicator_o,
	input wire logic			rx_full_indicator_oe,
	input wire logic			tx_pending_flag_o,
	input wire logic			tx_pending_flag_oe
);
	logic	usb;
	logic	sw;
	assign usb = link_ev.usb_bulk_in_ep1 | link_ev.usb_bulk_out_ep2;
	// USB wins a same-cycle tie, so serial checks only look at lone serial events
	assign sw = !usb && !tx_byte_busy;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_usb; usb && !tx_byte_busy |=> tx_dest; endproperty
	a_usb: assert property (p_usb) else $error("usb event missed");
	property p_uart; link_ev.uart_rx_byte && sw && cfg.mode == 2'h0 |=> !tx_dest; endproperty
	a_uart: assert property (p_uart) else $error("uart event missed");
	property p_i2c; link_ev.i2c_addr_match && sw && cfg.mode == 2'h2 |=> !tx_dest; endproperty
	a_i2c: assert property (p_i2c) else $error("i2c event missed");
	property p_spi; (link_ev.spi_write_cmd || link_ev.spi_read_cmd || link_ev.spi_status_cmd)
		&& sw && cfg.mode == 2'h3 |=> !tx_dest; endproperty
	a_spi: assert property (p_spi) else $error("spi command missed");
	property p_ready; rx_free_space >= 12'h080 |=> !rx_full_indicator_o; endproperty
	a_ready: assert property (p_ready) else $error("ready missed");
	property p_hold; tx_byte_busy |=> $stable(tx_dest); endproperty
	a_hold: assert property (p_hold) else $error("switch mid byte");
	property p_rst; $rose(rst_n) |-> (!tx_dest)[*3]; endproperty
	a_rst: assert property (p_rst) else $error("not serial after reset");
	property p_hiz; $rose(rst_n) |-> (!rx_full_indicator_oe && !tx_pending_flag_oe)[*3]; endproperty
	a_hiz: assert property (p_hiz) else $error("driven during init");
	property p_busy; rx_free_space <= 12'h03e |=> rx_full_indicator_o; endproperty
	a_busy: assert property (p_busy) else $error("busy missed");
	property p_pend; tx_pending_flag_oe |=> tx_pending_flag_o != $past(tx_empty); endproperty
	a_pend: assert property (p_pend) else $error("pending flag wrong");
	c_usb: cover property (usb && !tx_byte_busy);
	c_defer: cover property ($fell(tx_byte_busy) ##1 $fell(tx_dest));
	c_full: cover property ($rose(rx_full_indicator_o));
endmodule
bind hlsr_top hlsr_top_chk hlsr_top_chk_inst (.*);
`default_nettype wire

// file: tb/hlsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module hlsr_host (
	input wire logic		clk,
	input wire logic		go,
	input wire logic [2:0]		sel,
	input wire logic		ready,
	output var hlsr_pkg::hlsr_event_t	ev
);
	always_ff @(posedge clk)
		ev <= (go && ready) ? hlsr_pkg::hlsr_event_t'(7'h1 << sel) : '0;
endmodule
`default_nettype wire

// file: tb/host_link_select_reset_bench.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_select_reset_bench;
	logic	clk, rst_n, test_strap_n, go, init_done, load_done, tx_empty, tx_byte_busy;
	logic	serial_mode_jumper_a, serial_mode_jumper_b, slave_addr_jumper_a, slave_addr_jumper_b;
	logic	baud_jumper_a, baud_jumper_b, app_autostart_jumper, serial_txd_in, exec_enable;
	logic	serial_txd_o, serial_txd_oe, tx_pending_flag_o, tx_pending_flag_oe;
	logic	rx_full_indicator_o, rx_full_indicator_oe;
	logic [2:0]	sel;
	logic [6:0]	i2c_own_addr;
	logic [7:0]	tx_head_byte, read_byte;
	logic [11:0]	rx_free_space;
	hlsr_pkg::hlsr_event_t	link_ev;
	hlsr_pkg::hlsr_dest_t	tx_dest;
	hlsr_pkg::hlsr_cfg_t	cfg;
	int	error_cnt, n_compared, cyc;
	hlsr_top hlsr_top_inst (.*);
	hlsr_host hlsr_host_inst (.clk, .go, .sel, .ready(rx_full_indicator_oe & !rx_full_indicator_o),
		.ev(link_ev));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task chk(input logic [11:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task boot(input logic [1:0] m, input logic [3:0] j);
		rst_n = 0;
		{init_done, load_done} = 0;
		{serial_mode_jumper_b, serial_mode_jumper_a} = m;
		{app_autostart_jumper, test_strap_n, slave_addr_jumper_b, slave_addr_jumper_a} = j;
		{baud_jumper_b, baud_jumper_a} = j[1:0];
		wt(12);
		rst_n = 1;
		wt(6);
		chk(rx_full_indicator_oe | tx_pending_flag_oe | serial_txd_oe, 0);
		chk(tx_dest, 0);
		chk(cfg.mode, m);
		chk({cfg.autostart, cfg.test_mode}, {~j[3], ~j[2]});
		chk(i2c_own_addr, 7'h50 + {5'h0, ~j[1:0]});
		chk(cfg.addr_sel, j[1:0]);
		chk(cfg.baud_sel, j[1:0]);
		init_done = 1;
		wt(3);
		chk(rx_full_indicator_oe & tx_pending_flag_oe & serial_txd_oe, 1);
		chk(exec_enable, j[3]);
		load_done = 1;
		wt(2);
		chk(exec_enable, 1);
	endtask
	task send(input logic [2:0] s, input logic d);
		sel = s;
		serial_txd_in = s[0];
		go = 1;
		wt(1);
		go = 0;
		wt(2);
		chk(tx_dest, d);
		chk(serial_txd_o, d | s[0]);
	endtask
	task lv(input logic [11:0] f, input logic b);
		rx_free_space = f;
		wt(2);
		chk(rx_full_indicator_o, b);
	endtask
	task late_switch;
		tx_byte_busy = 1;
		send(3'h4, 1'h1);
		tx_byte_busy = 0;
		wt(2);
		chk(tx_dest, 0);
	endtask
	task txbuf;
		chk(read_byte, 8'hff);
		chk(tx_pending_flag_o, 0);
		tx_empty = 0;
		wt(2);
		chk(read_byte, 8'h5a);
		chk(tx_pending_flag_o, 1);
		tx_empty = 1;
		wt(2);
		chk(read_byte, 8'hff);
		chk(tx_pending_flag_o, 0);
	endtask
	task rsvd_mode;
		boot(2'h1, 4'h5);
		send(3'h6, 1'h1);
		send(3'h4, 1'h1);
		send(3'h2, 1'h1);
		send(3'h0, 1'h1);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		{go, sel, tx_byte_busy, baud_jumper_a, baud_jumper_b, serial_txd_in} = 0;
		tx_empty = 1;
		rx_free_space = 12'h080;
		tx_head_byte = 8'h5a;
		boot(2'h0, 4'hf);
		send(3'h6, 1'h1);
		send(3'h4, 1'h0);
		send(3'h5, 1'h1);
		send(3'h3, 1'h1);
		late_switch();
		lv(12'h03f, 0);
		lv(12'h03e, 1);
		lv(12'h07f, 1);
		lv(12'h080, 0);
		txbuf();
		boot(2'h3, 4'hf);
		for (int i = 1; i < 4; i++) begin
			send(3'h6, 1'h1);
			send(3'(i), 1'h0);
		end
		boot(2'h2, 4'h0);
		send(3'h6, 1'h1);
		send(3'h4, 1'h1);
		send(3'h0, 1'h0);
		rsvd_mode();
		results();
	end
endmodule
`default_nettype wire
